// File: sse_cfg.svh
// Constants for the subtract and sleep execution block.
// Assumes inclusion by name from the package and the execution core.
`ifndef SSE_CFG_SVH
`define SSE_CFG_SVH
`define SSE_PHASES        4
`define SSE_PH_DECODE     4'h1
`define SSE_PH_READ       4'h2
`define SSE_PH_EXEC       4'h4
`define SSE_PH_WRITE      4'h8
`define SSE_WDT_WIDTH     8
`define SSE_PRE_WIDTH     8
`define SSE_FLAG_OV       3
`define SSE_FLAG_Z        2
`define SSE_FLAG_DC       1
`define SSE_FLAG_C        0
`define SSE_OP_NONE       3'h0
`define SSE_OP_LIT_SUB    3'h1
`define SSE_OP_FILE_SUB   3'h2
`define SSE_OP_FILE_SUBB  3'h3
`define SSE_OP_SLEEP      3'h4
`endif

// File: sse_exec.sv
// Execution core for subtract forms and the power-down instruction.
// Assumes the caller presents one instruction per four-phase cycle.
`timescale 1ns/100ps
`include "sse_cfg.svh"
module sse_exec
   import sse_pkg::*;
(
   input  wire logic          clk_sys,             // Oscillator clock
   input  wire logic          reset_n,             // Synchronous reset, low
   input  wire logic          ext_clock_mode,      // External-clock mode select
   input  wire sse_instr_type instr,               // Instruction, held over a cycle
   input  wire logic          wake_event,          // Interrupt style wake-up
   input  wire logic          watchdog_tick,       // Prescaler input tick
   output logic               instr_taken,         // Pulse at decode phase
   output logic [3:0]         phase,               // One-hot phase
   output logic               sleeping,            // Sleep state
   output logic               osc_run,             // Oscillator enable
   output logic               cycle_clock_output,  // Cycle marker pin
   output logic [7:0]         working_register,    // Accumulator
   output logic [7:0]         file_write_data,     // Data back to file
   output logic               file_write_en,       // File write strobe
   output logic [3:0]         status_flags,        // OV,Z,DC,C
   output logic               timeout_flag_n,      // Time-out status, low active
   output logic               power_down_flag_n,   // Power-down status, low active
   output logic [7:0]         watchdog_counter     // Watchdog count
);
   typedef enum logic [3:0] {
      PH_DECODE = `SSE_PH_DECODE,
      PH_READ   = `SSE_PH_READ,
      PH_EXEC   = `SSE_PH_EXEC,
      PH_WRITE  = `SSE_PH_WRITE
   } sse_phase_type;

   sse_phase_type   phase_q;
   sse_phase_type   phase_d;
   sse_instr_type   instr_q;
   sse_alu_type     alu_q;
   sse_alu_type     alu_res;
   logic            sleep_q;
   logic [7:0]      work_q;
   logic [7:0]      fwd_q;
   logic            fwe_q;
   logic [3:0]      flags_q;
   logic            to_n_q;
   logic            pd_n_q;
   logic [7:0]      wdt_q;
   logic [7:0]      pre_q;
   logic            cycle_clock_output_q;
   logic [2:0]      wake_sync_q;

   // Literal form decode; shared by operand and destination choice
   function automatic logic op_is_literal(input sse_op_type op);
      return (op == SSE_LIT_SUB);
   endfunction

   // Any subtract form; other codes leave the datapath untouched
   function automatic logic op_is_subtract(input sse_op_type op);
      return (op == SSE_LIT_SUB) | (op == SSE_FILE_SUB) | (op == SSE_FILE_SUBB);
   endfunction

   // Phase sequencer: four oscillator periods per cycle, frozen in sleep
   always_comb
   begin
      unique case (phase_q)
         PH_DECODE: phase_d = PH_READ;
         PH_READ:   phase_d = PH_EXEC;
         PH_EXEC:   phase_d = PH_WRITE;
         PH_WRITE:  phase_d = PH_DECODE;
         default:   phase_d = PH_DECODE;
      endcase
   end

   // Operand choice: literal or file as minuend
   wire logic [7:0] minuend   = op_is_literal(instr_q.op) ? instr_q.literal : instr_q.file_value;
   wire logic       use_borrow = (instr_q.op == SSE_FILE_SUBB);
   wire logic       borrow_in  = use_borrow & ~flags_q[`SSE_FLAG_C];
   wire logic       is_sub     = op_is_subtract(instr_q.op);
   wire logic       to_file    = ~op_is_literal(instr_q.op) & instr_q.dest_file;
   wire logic       at_exec    = (phase_q == PH_EXEC) & ~sleep_q;
   wire logic       at_write   = (phase_q == PH_WRITE) & ~sleep_q;
   wire logic       do_sleep   = at_exec & (instr_q.op == SSE_SLEEP);
   // Last prescaler count; the counter steps on the tick after it
   wire logic       pre_wrap   = (pre_q == 8'hFF);
   // Whole prescaler and counter chain at its end while asleep wakes the core
   wire logic       wdt_expire = sleep_q & watchdog_tick & pre_wrap & (wdt_q == 8'hFF);
   // Wake input filtered: counts once second and third stages are both high
   wire logic       wake_ok    = wake_sync_q[1] & wake_sync_q[2];

   sse_subtractor u_sub
   (
      .minuend    (minuend),
      .subtrahend (work_q),
      .borrow_in  (borrow_in),
      .result     (alu_res)
   );

   // Phase and instruction capture
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         phase_q <= PH_DECODE;
         instr_q <= '0;
      end
      else if (!sleep_q)
      begin
         phase_q <= phase_d;
         if (phase_q == PH_READ)
            instr_q <= instr;
      end
   end

   // Execute then write back within the same cycle
   // Flags and result land together, so a borrow chain sees a settled carry
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         alu_q   <= '0;
         work_q  <= 8'h00;
         fwd_q   <= 8'h00;
         fwe_q   <= 1'b0;
         flags_q <= 4'h0;
      end
      else
      begin
         fwe_q <= 1'b0;
         if (at_exec)
            alu_q <= alu_res;
         if (at_write & is_sub)
         begin
            flags_q <= {alu_q.overflow_flag, alu_q.zero, alu_q.digit_carry_flag, alu_q.carry};
            if (to_file)
            begin
               fwd_q <= alu_q.value;
               fwe_q <= 1'b1;
            end
            else
               work_q <= alu_q.value;
         end
      end
   end

   // Sleep state, status bits and wake-up
   // Entry outranks a wake in the same cycle; a held wake ends it a cycle later
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         sleep_q     <= 1'b0;
         to_n_q      <= 1'b1;
         pd_n_q      <= 1'b1;
         wake_sync_q <= 3'h0;
      end
      else
      begin
         wake_sync_q <= {wake_sync_q[1:0], wake_event};
         if (do_sleep)
         begin
            sleep_q <= 1'b1;
            pd_n_q  <= 1'b0;
            to_n_q  <= 1'b1;
         end
         else if (wdt_expire)
         begin
            sleep_q <= 1'b0;
            to_n_q  <= 1'b0;
         end
         else if (sleep_q & wake_ok)
            sleep_q <= 1'b0;
      end
   end

   // Watchdog and prescaler; keeps running in sleep so it can wake the core
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n | do_sleep)
      begin
         wdt_q <= 8'h00;
         pre_q <= 8'h00;
      end
      else if (watchdog_tick)
      begin
         pre_q <= pre_q + 8'h01;
         if (pre_wrap)
            wdt_q <= wdt_q + 8'h01;
      end
   end

   // Cycle clock: high for decode and read, low for execute and write
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         cycle_clock_output_q <= 1'b0;
      else
         cycle_clock_output_q <= ext_clock_mode & ~sleep_q & (phase_d == PH_DECODE | phase_d == PH_READ);
   end

   // Outputs
   assign instr_taken        = (phase_q == PH_DECODE) & ~sleep_q;
   assign phase              = phase_q;
   assign sleeping           = sleep_q;
   assign osc_run            = ~sleep_q;
   assign cycle_clock_output = cycle_clock_output_q;
   assign working_register   = work_q;
   assign file_write_data    = fwd_q;
   assign file_write_en      = fwe_q;
   assign status_flags       = flags_q;
   assign timeout_flag_n     = to_n_q;
   assign power_down_flag_n  = pd_n_q;
   assign watchdog_counter   = wdt_q;
endmodule

// File: sse_exec_chk.sv
// Port checker for the subtract and sleep execution core.
// Assumes a bind into sse_exec from the testbench top.
`timescale 1ns/100ps
module sse_exec_chk
   import sse_pkg::*;
(
   input wire logic       clk_sys,            // Clock
   input wire logic       reset_n,            // Reset, low
   input wire logic       ext_clock_mode,     // Clock pin mode
   input wire logic       instr_taken,        // Decode marker
   input wire logic [3:0] phase,              // One-hot phase
   input wire logic       sleeping,           // Sleep state
   input wire logic       osc_run,            // Oscillator on
   input wire logic       cycle_clock_output, // Cycle pin
   input wire logic       file_write_en,      // File strobe
   input wire logic [3:0] status_flags,       // OV,Z,DC,C
   input wire logic       timeout_flag_n,     // Time-out, low
   input wire logic       power_down_flag_n,  // Power-down, low
   input wire logic [7:0] watchdog_counter    // Watchdog
);
   // One domain, so one clock and one reset for all
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   // Awake cycles in a row with the pin enabled; the period check needs five
   logic [2:0] run_cnt_q;
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n || !ext_clock_mode || sleeping)
         run_cnt_q <= 3'h0;
      else if (run_cnt_q != 3'h7)
         run_cnt_q <= run_cnt_q + 3'h1;
   end

   AST_ROTATE: assert property ((phase == 4'h1 && !sleeping) |=> phase == 4'h2 ##1 phase == 4'h4)
      else $error("phase order broken");
   AST_ONEHOT: assert property ($onehot(phase))
      else $error("phase not one-hot");
   AST_OSC: assert property (osc_run == !sleeping)
      else $error("oscillator runs in sleep");
   AST_TAKEN: assert property (instr_taken == (phase == 4'h1 && !sleeping))
      else $error("decode marker wrong");
   AST_SLEEP_IN: assert property ($rose(sleeping) |-> !power_down_flag_n && timeout_flag_n
      && watchdog_counter == 8'h00 && $stable(status_flags))
      else $error("sleep entry state wrong");
   AST_WRITE: assert property (file_write_en |-> phase == 4'h1 ##1 !file_write_en)
      else $error("file strobe not one cycle");
   AST_TO_WAKE: assert property ($fell(timeout_flag_n) |-> $past(sleeping))
      else $error("time-out cleared while awake");
   AST_CLK_OFF: assert property ((!ext_clock_mode && !$past(ext_clock_mode)) |-> !cycle_clock_output)
      else $error("cycle pin active when off");
   AST_CLK_PER: assert property ((run_cnt_q >= 3'h5)
      |-> cycle_clock_output == $past(cycle_clock_output, 4))
      else $error("cycle pin period not four");
   AST_FROZEN: assert property ((sleeping && $past(sleeping)) |-> $stable(phase) && !instr_taken)
      else $error("phases advance in sleep");
   // Main scenarios reached
   COV_SLEEP: cover property ($rose(sleeping));
   COV_WDT: cover property ($fell(timeout_flag_n));
   COV_FWR: cover property (file_write_en);
   COV_PIN_WAKE: cover property ($fell(sleeping) && timeout_flag_n);
endmodule

// File: sse_pkg.sv
// Types for the subtract and sleep execution block.
// Assumes sse_cfg.svh holds the numeric constants.
`include "sse_cfg.svh"
package sse_pkg;
   typedef enum logic [2:0] {
      SSE_NONE      = `SSE_OP_NONE,
      SSE_LIT_SUB   = `SSE_OP_LIT_SUB,
      SSE_FILE_SUB  = `SSE_OP_FILE_SUB,
      SSE_FILE_SUBB = `SSE_OP_FILE_SUBB,
      SSE_SLEEP     = `SSE_OP_SLEEP
   } sse_op_type;

   // One instruction as presented to the block
   typedef struct packed {
      sse_op_type op;
      logic       dest_file;
      logic [7:0] literal;
      logic [7:0] file_value;
   } sse_instr_type;

   // Subtract result with its flags
   typedef struct packed {
      logic [7:0] value;
      logic       overflow_flag;
      logic       zero;
      logic       digit_carry_flag;
      logic       carry;
   } sse_alu_type;
endpackage

// File: sse_subtractor.sv
// Eight-bit subtractor: a - b - borrow with the four arithmetic flags.
// Assumes purely combinational use by the execution core.
`timescale 1ns/100ps
module sse_subtractor
   import sse_pkg::*;
(
   input  wire logic [7:0] minuend,    // Left operand
   input  wire logic [7:0] subtrahend, // Right operand
   input  wire logic       borrow_in,  // Extra one to take away
   output sse_alu_type     result      // Difference and flags
);
   // Add the complement; carry out set means no borrow
   wire logic [8:0] full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, ~borrow_in};
   wire logic [4:0] low_sum  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, ~borrow_in};
   wire logic [7:0] diff     = full_sum[7:0];

   // Flag derivation
   assign result.value            = diff;
   assign result.carry            = full_sum[8];
   assign result.digit_carry_flag = low_sum[4];
   assign result.zero             = (diff == 8'h00);
   assign result.overflow_flag    = (minuend[7] ^ subtrahend[7]) & (diff[7] ^ minuend[7]);
endmodule

// File: tb_top.sv
// Self-checking bench for the subtract and sleep execution core.
// Assumes sse_exec and sse_exec_chk are compiled before it.
`timescale 1ns/100ps
module tb_top
   import sse_pkg::*;
;
   logic          clk_sys = 0, reset_n = 0, ext_clock_mode = 0, wake_event = 0, watchdog_tick = 0;
   sse_instr_type instr = '0;
   logic          instr_taken, sleeping, osc_run, cycle_clock_output, file_write_en;
   logic          timeout_flag_n, power_down_flag_n;
   logic [3:0]    phase, status_flags;
   logic [7:0]    working_register, file_write_data, watchdog_counter;
   logic [7:0]    w_m = 0;
   logic          c_m = 0;
   int            error_cnt = 0, total_checks = 0;
   logic [7:0]    lits [7] = '{8'h01, 8'h02, 8'h01, 8'h03, 8'h80, 8'h7F, 8'h00};

   sse_exec dut (.clk_sys, .reset_n, .ext_clock_mode, .instr, .wake_event, .watchdog_tick, .instr_taken,
      .phase, .sleeping, .osc_run, .cycle_clock_output, .working_register, .file_write_data,
      .file_write_en, .status_flags, .timeout_flag_n, .power_down_flag_n, .watchdog_counter);

   // Free-running 100 MHz clock
   initial forever #5 clk_sys = ~clk_sys;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic end_sim;
      if (error_cnt == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Inputs always move one step after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // Back to decode, bounded so a stuck phase cannot hang
   task automatic align;
      for (int i = 0; i < 50 && !(phase === 4'h1 && sleeping === 1'b0); i++)
         tick(1);
   endtask

   // One subtract over a full cycle, judged against own model
   task automatic run(input sse_op_type op, input logic d, input logic [7:0] k, input logic [7:0] f);
      logic [7:0] a;
      logic       bi;
      logic [8:0] df;
      logic [4:0] dn;
      logic       wr;
      a = (op == SSE_LIT_SUB) ? k : f;
      bi = (op == SSE_FILE_SUBB) & ~c_m;
      df = {1'b0, a} - {1'b0, w_m} - bi;
      dn = {1'b0, a[3:0]} - {1'b0, w_m[3:0]} - bi;
      wr = d & (op != SSE_LIT_SUB);
      instr = '{op, d, k, f};
      tick(4);
      chk(status_flags, {(a[7] != w_m[7]) && (df[7] != a[7]), df[7:0] == 0, ~dn[4], ~df[8]});
      chk(file_write_en, wr);
      if (wr)
         chk(file_write_data, df[7:0]);
      else
         w_m = df[7:0];
      chk(working_register, w_m);
      c_m = ~df[8];
   endtask

   // Power-down, then a subtract that must be ignored
   task automatic doze;
      instr = '{SSE_SLEEP, 1'b0, 8'h00, 8'h00};
      tick(4);
      chk(sleeping, 1);
      chk(power_down_flag_n, 0);
      chk(timeout_flag_n, 1);
      chk(watchdog_counter, 0);
      instr = '{SSE_LIT_SUB, 1'b0, 8'h55, 8'h00};
      tick(8);
      chk(working_register, w_m);
      instr = '0;
   endtask

   task automatic clock_pin;
      int n;
      n = 0;
      instr = '0;
      ext_clock_mode = 1;
      watchdog_tick = 1;
      tick(4);
      for (int i = 0; i < 300; i++)
      begin
         n += (i < 8 && cycle_clock_output === 1'b1);
         tick(1);
      end
      chk(n, 4);
      ext_clock_mode = 0;
   endtask

   task automatic wdt_wake;
      int n;
      doze();
      for (n = 0; n < 70000 && sleeping !== 1'b0; n++)
         tick(1);
      chk(n > 65400 && n < 65600, 1);
      chk(timeout_flag_n, 0);
      watchdog_tick = 0;
   endtask

   // Main sequence
   initial
   begin
      tick(20);
      reset_n = 1;
      chk({power_down_flag_n, timeout_flag_n, osc_run, status_flags}, 8'h70);
      foreach (lits[i]) run(SSE_LIT_SUB, 1'b0, lits[i], 8'h00);
      run(SSE_FILE_SUB, 1'b1, 8'h00, 8'h03);
      run(SSE_FILE_SUB, 1'b0, 8'h00, 8'hFE);
      run(SSE_FILE_SUBB, 1'b0, 8'h00, 8'h19);
      run(SSE_FILE_SUBB, 1'b1, 8'h00, 8'h0D);
      run(SSE_FILE_SUBB, 1'b0, 8'h00, 8'h05);
      clock_pin();
      align();
      doze();
      wake_event = 1;
      for (int i = 0; i < 20 && sleeping !== 1'b0; i++)
         tick(1);
      wake_event = 0;
      chk({sleeping, timeout_flag_n}, 8'h01);
      align();
      run(SSE_LIT_SUB, 1'b0, 8'h10, 8'h00);
      wdt_wake();
      end_sim();
   end

   // Hang guard, well beyond the watchdog sleep
   initial
   begin
      #900000;
      error_cnt++;
      end_sim();
   end
endmodule

bind sse_exec sse_exec_chk u_chk (.clk_sys, .reset_n, .ext_clock_mode, .instr_taken, .phase, .sleeping,
   .osc_run, .cycle_clock_output, .file_write_en, .status_flags, .timeout_flag_n, .power_down_flag_n,
   .watchdog_counter);
